/* include/pbmd_cfg.svh */
/*
 pbmd_cfg.svh: offsets, fields, reset values and adders of the
 protection bit map decoder. Assumes a 32-bit AXI4-Lite bus.
*/
`ifndef PBMD_CFG_SVH
`define PBMD_CFG_SVH

// register byte offsets
`define PBMD_OFS_DENSITY   8'h00
`define PBMD_OFS_EXP8      8'h04
`define PBMD_OFS_EXP32     8'h08
`define PBMD_OFS_ADDER     8'h0C
`define PBMD_OFS_STATUS    8'h10
`define PBMD_OFS_LOCATION  8'h14
`define PBMD_OFS_COUNT64   8'h18
`define PBMD_OFS_QUERY     8'h1C
`define PBMD_OFS_QRESULT   8'h20
`define PBMD_OFS_REGION    8'h40
`define PBMD_REGION_STRIDE 8'h10

// reset values
`define PBMD_RST_DENSITY   4'h7
`define PBMD_RST_EXP8      8'h02
`define PBMD_RST_EXP32     8'h00
`define PBMD_RST_ADDER     8'h00

// legal density constants
`define PBMD_M_MIN         4'h4
`define PBMD_M_MAX         4'h8

// sector type codes
`define PBMD_TYPE_8K       4'h2
`define PBMD_TYPE_32K      4'h3
`define PBMD_TYPE_64K      4'h4

// constant adders, regions bottom to top
`define PBMD_ADD_BOT8_FIRST  8'hFF
`define PBMD_ADD_BOT8_LAST   8'h04
`define PBMD_ADD_LO32        8'hFD
`define PBMD_ADD_64K_FIRST   8'h00
`define PBMD_ADD_64K_LAST    8'hFC
`define PBMD_ADD_HI32        8'hFE
`define PBMD_ADD_TOP8_FIRST  8'h07
`define PBMD_ADD_TOP8_LAST   8'h0E

// AXI responses
`define PBMD_RESP_OKAY     2'h0
`define PBMD_RESP_SLVERR   2'h2

`endif

/* include/pbmd_pkg.sv */
/*
 pbmd_pkg: types of the protection bit map decoder.
 Assumes pbmd_cfg.svh sits on the include path.
*/
package pbmd_pkg;

    localparam int PBMD_REGIONS = 5;
    localparam int PBMD_LOC_W   = 10;

    // one decoded region of the map
    typedef struct packed {
        logic [3:0]            kind;
        logic [31:0]           count;
        logic [PBMD_LOC_W-1:0] first;
        logic [PBMD_LOC_W-1:0] last;
    } pbmd_region_s;

    // bus channel state
    typedef enum logic [0:0] {
        PBMD_IDLE = 1'b0,
        PBMD_RESP = 1'b1
    } pbmd_chan_e;

endpackage

/* hw/pbmd_decoder.sv */
/*
 pbmd_decoder: turns density and table fields of a flash parameter
 table into block counts and protection register bit locations,
 reachable over AXI4-Lite. Assumes one clock and an AXI4-Lite
 master that keeps the usual valid/ready handshakes.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pbmd_cfg.svh"

module pbmd_decoder
    import pbmd_pkg::*;
(
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESETN,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output var  logic        S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output var  logic        S_AXI_WREADY,
    output var  logic [1:0]  S_AXI_BRESP,
    output var  logic        S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output var  logic        S_AXI_ARREADY,
    output var  logic [31:0] S_AXI_RDATA,
    output var  logic [1:0]  S_AXI_RRESP,
    output var  logic        S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    localparam int W = PBMD_LOC_W;

    // per region type and adders, bottom of memory first
    localparam logic [3:0] REG_KIND [PBMD_REGIONS] = '{
        `PBMD_TYPE_8K, `PBMD_TYPE_32K, `PBMD_TYPE_64K,
        `PBMD_TYPE_32K, `PBMD_TYPE_8K};
    localparam logic [7:0] REG_FIRST [PBMD_REGIONS] = '{
        `PBMD_ADD_BOT8_FIRST, `PBMD_ADD_LO32, `PBMD_ADD_64K_FIRST,
        `PBMD_ADD_HI32, `PBMD_ADD_TOP8_FIRST};
    localparam logic [7:0] REG_LAST [PBMD_REGIONS] = '{
        `PBMD_ADD_BOT8_LAST, `PBMD_ADD_LO32, `PBMD_ADD_64K_LAST,
        `PBMD_ADD_HI32, `PBMD_ADD_TOP8_LAST};
    // location of one table field for density m
    function automatic logic [W-1:0] loc_of(input logic [3:0] m,
                                            input logic [7:0] c);
        logic [W-1:0] base;
        base = (W'(1) << m) + W'(1);
        if (c == 8'h00)
            loc_of = '0;
        else
            loc_of = base + {{(W-8){c[7]}}, c};
    endfunction
    // two to the power of a byte, zero when it overflows 32 bits
    function automatic logic [31:0] pow2(input logic [7:0] n);
        pow2 = (n < 8'h20) ? (32'h1 << n[4:0]) : 32'h0;
    endfunction

    logic [3:0]   density;
    logic [7:0]   exp8;
    logic [7:0]   exp32;
    logic [7:0]   adder;
    logic [W-1:0] query;
    logic [W-1:0] location;
    logic [31:0]  qresult;
    pbmd_region_s region [PBMD_REGIONS];
    pbmd_region_s next_region [PBMD_REGIONS];
    logic [PBMD_REGIONS-1:0] hit;
    logic [31:0]  next_qresult;
    pbmd_chan_e   wr_state;
    logic         aw_held;
    logic         w_held;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         wr_fire;
    logic         wr_ok;
    logic [31:0]  next_rdata;
    logic         rd_ok;

    // free adder decode for software
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            location <= '0;
        else
            location <= loc_of(density, adder);
    end
    // region table, one entry per region
    genvar r;
    generate
        for (r = 0; r < PBMD_REGIONS; r++)
        begin : g_region
            always_comb
            begin
                next_region[r].kind  = REG_KIND[r];
                next_region[r].first = loc_of(density, REG_FIRST[r]);
                next_region[r].last  = loc_of(density, REG_LAST[r]);
                unique case (REG_KIND[r])
                    `PBMD_TYPE_8K:  next_region[r].count = pow2(exp8);
                    `PBMD_TYPE_32K: next_region[r].count = pow2(exp32);
                    default:        next_region[r].count = (32'h1 << density) - 32'h2;
                endcase
            end
            always_ff @(posedge I_CLOCK or negedge I_RESETN)
            begin
                if (!I_RESETN)
                    region[r] <= '0;
                else
                    region[r] <= next_region[r];
            end
            // one hit bit per region, set when the query lies between first and last
            assign hit[r] = (query >= region[r].first) &&
                            (query <= region[r].last);
        end
    endgenerate

    // query of one protection bit: region, offset, lock kind
    always_comb
    begin
        next_qresult = 32'h0;
        for (int i = PBMD_REGIONS - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                next_qresult[31]    = 1'b1;
                next_qresult[26:24] = 3'(i);
                next_qresult[W-1:0] = query - region[i].first;
                next_qresult[17:16] = (region[i].kind == `PBMD_TYPE_8K) ?
                                      {query[0], ~query[0]} : 2'h0;
            end
        end
    end

    // query result register
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            qresult <= 32'h0;
        else
            qresult <= next_qresult;
    end

    // write channel: address and data in either order
    assign wr_fire = aw_held && w_held && (wr_state == PBMD_IDLE);
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            else if (wr_fire)
                aw_held <= 1'b0;
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            else if (wr_fire)
                w_held <= 1'b0;
        end
    end

    // ready only while the slot is free
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY)
                             && (wr_state == PBMD_IDLE);
            S_AXI_WREADY  <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY)
                             && (wr_state == PBMD_IDLE);
        end
    end

    // address decode of writes; illegal density refused
    always_comb
    begin
        unique case (aw_addr)
            `PBMD_OFS_DENSITY: wr_ok = (w_data[3:0] >= `PBMD_M_MIN) &&
                                       (w_data[3:0] <= `PBMD_M_MAX);
            `PBMD_OFS_EXP8, `PBMD_OFS_EXP32, `PBMD_OFS_ADDER, `PBMD_OFS_QUERY: wr_ok = 1'b1;
            default:           wr_ok = 1'b0;
        endcase
    end

    // writable fields, all in the low bytes
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            density <= `PBMD_RST_DENSITY;
            exp8    <= `PBMD_RST_EXP8;
            exp32   <= `PBMD_RST_EXP32;
            adder   <= `PBMD_RST_ADDER;
            query   <= '0;
        end
        else if (wr_fire && wr_ok)
        begin
            unique case (aw_addr)
                `PBMD_OFS_DENSITY: if (w_strb[0]) density <= w_data[3:0];
                `PBMD_OFS_EXP8:    if (w_strb[0]) exp8 <= w_data[7:0];
                `PBMD_OFS_EXP32:   if (w_strb[0]) exp32 <= w_data[7:0];
                `PBMD_OFS_ADDER:   if (w_strb[0]) adder <= w_data[7:0];
                default:
                begin
                    if (w_strb[0]) query[7:0] <= w_data[7:0];
                    if (w_strb[1]) query[W-1:8] <= w_data[W-1:8];
                end
            endcase
        end
    end

    // write response
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            wr_state     <= PBMD_IDLE;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `PBMD_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            wr_state     <= PBMD_RESP;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_ok ? `PBMD_RESP_OKAY : `PBMD_RESP_SLVERR;
        end
        else if (S_AXI_BVALID && S_AXI_BREADY)
        begin
            wr_state     <= PBMD_IDLE;
            S_AXI_BVALID <= 1'b0;
        end
    end

    // read decode over registered results
    always_comb
    begin
        next_rdata = 32'h0;
        rd_ok      = 1'b1;
        unique case (S_AXI_ARADDR)
            `PBMD_OFS_DENSITY:  next_rdata[3:0] = density;
            `PBMD_OFS_EXP8:     next_rdata[7:0] = exp8;
            `PBMD_OFS_EXP32:    next_rdata[7:0] = exp32;
            `PBMD_OFS_ADDER:    next_rdata[7:0] = adder;
            `PBMD_OFS_STATUS:   next_rdata[1:0] = {region[1].count == 32'h0,
                                                   region[0].count == 32'h0};
            `PBMD_OFS_LOCATION: next_rdata[W-1:0] = location;
            `PBMD_OFS_COUNT64:  next_rdata = region[2].count;
            `PBMD_OFS_QUERY:    next_rdata[W-1:0] = query;
            `PBMD_OFS_QRESULT:  next_rdata = qresult;
            default:
            begin
                rd_ok = 1'b0;
                for (int i = 0; i < PBMD_REGIONS; i++)
                begin
                    if (S_AXI_ARADDR[7:4] == 4'(i + 4))
                    begin
                        rd_ok = 1'b1;
                        unique case (S_AXI_ARADDR[3:0])
                            4'h0: next_rdata[3:0] = region[i].kind;
                            4'h4: next_rdata = region[i].count;
                            4'h8: next_rdata[W-1:0] = region[i].first;
                            4'hC: next_rdata[W-1:0] = region[i].last;
                            default: rd_ok = 1'b0;
                        endcase
                    end
                end
            end
        endcase
    end

    // read channel
    always_ff @(posedge I_CLOCK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= `PBMD_RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_ok ? next_rdata : 32'h0;
            S_AXI_RRESP   <= rd_ok ? `PBMD_RESP_OKAY : `PBMD_RESP_SLVERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
        else if (!S_AXI_RVALID)
            S_AXI_ARREADY <= 1'b1;
    end

endmodule
`default_nettype wire

/* testbench/pbmd_decoder_asserts.sv */
/*
 pbmd_decoder_asserts: bus timing and fixed map checks on the decoder ports.
 Assumes one clock; reads answer one cycle, writes two cycles after the handshake.
*/
`timescale 1ns/1ps
`default_nettype none

module pbmd_decoder_asserts (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESETN,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    input  wire logic        S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic        S_AXI_WVALID,
    input  wire logic        S_AXI_WREADY,
    input  wire logic [1:0]  S_AXI_BRESP,
    input  wire logic        S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    input  wire logic        S_AXI_ARREADY,
    input  wire logic [31:0] S_AXI_RDATA,
    input  wire logic        S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);

    // handshake helpers
    wire wr_hs = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;

    // answer timing and holding
    property p_wr_lat;
        wr_hs |=> ##1 S_AXI_BVALID;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("late write answer");
    property p_rd_lat;
        ar_hs |=> S_AXI_RVALID;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("late read answer");
    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");

    // fixed region kinds and the 64K start bit
    property p_type8;
        ar_hs && S_AXI_ARADDR inside {8'h40, 8'h80} |=> S_AXI_RDATA == 32'h2;
    endproperty
    a_type8: assert property (p_type8) else $error("8K type wrong");
    property p_type32;
        ar_hs && S_AXI_ARADDR inside {8'h50, 8'h70} |=> S_AXI_RDATA == 32'h3;
    endproperty
    a_type32: assert property (p_type32) else $error("32K type wrong");
    property p_type64;
        ar_hs && S_AXI_ARADDR == 8'h60 |=> S_AXI_RDATA == 32'h4;
    endproperty
    a_type64: assert property (p_type64) else $error("64K type wrong");
    property p_first64;
        ar_hs && S_AXI_ARADDR == 8'h68 |=> S_AXI_RDATA == 32'h0;
    endproperty
    a_first64: assert property (p_first64) else $error("64K start not 0");

    // densities outside 4..8 refused
    property p_bad_m;
        wr_hs && S_AXI_AWADDR == 8'h00 && !(S_AXI_WDATA[3:0] inside {[4:8]})
            |=> ##1 S_AXI_BRESP == 2'h2;
    endproperty
    a_bad_m: assert property (p_bad_m) else $error("bad density taken");
endmodule

bind pbmd_decoder pbmd_decoder_asserts chk_u (.*);

`default_nettype wire

/* testbench/pbmd_host_model.sv */
/*
 pbmd_host_model: AXI4-Lite master in the place of the host controller.
 Assumes its tasks are called one at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module pbmd_host_model (
    input  wire logic        I_CLOCK,
    output var  logic [7:0]  S_AXI_AWADDR,
    output var  logic        S_AXI_AWVALID,
    input  wire logic        S_AXI_AWREADY,
    output var  logic [31:0] S_AXI_WDATA,
    output var  logic [3:0]  S_AXI_WSTRB,
    output var  logic        S_AXI_WVALID,
    input  wire logic        S_AXI_WREADY,
    input  wire logic [1:0]  S_AXI_BRESP,
    input  wire logic        S_AXI_BVALID,
    output var  logic        S_AXI_BREADY,
    output var  logic [7:0]  S_AXI_ARADDR,
    output var  logic        S_AXI_ARVALID,
    input  wire logic        S_AXI_ARREADY,
    input  wire logic [31:0] S_AXI_RDATA,
    input  wire logic [1:0]  S_AXI_RRESP,
    input  wire logic        S_AXI_RVALID,
    output var  logic        S_AXI_RREADY
);
    // idle bus from time zero
    initial
    begin
        {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID, S_AXI_BREADY} = '0;
        {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        S_AXI_WSTRB = 4'hF;
    end

    // one write; to stays set when no answer comes
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r, output bit to);
        to = 1'b1;
        r = 2'h0;
        @(posedge I_CLOCK);
        {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID} <= {a, 1'b1, d, 1'b1};
        S_AXI_BREADY <= 1'b1;
        for (int n = 0; n < 50 && to; n++)
        begin
            @(posedge I_CLOCK);
            // released payload shows garbage, not the old value
            if (S_AXI_AWVALID && S_AXI_AWREADY)
                {S_AXI_AWADDR, S_AXI_AWVALID} <= {~a, 1'b0};
            if (S_AXI_WVALID && S_AXI_WREADY)
                {S_AXI_WDATA, S_AXI_WVALID} <= {~d, 1'b0};
            if (S_AXI_BVALID)
            begin
                r = S_AXI_BRESP;
                S_AXI_BREADY <= 1'b0;
                to = 1'b0;
            end
        end
    endtask

    // one read; to stays set when no answer comes
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r, output bit to);
        to = 1'b1;
        {d, r} = '0;
        @(posedge I_CLOCK);
        {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 1'b1, 1'b1};
        for (int n = 0; n < 50 && to; n++)
        begin
            @(posedge I_CLOCK);
            if (S_AXI_ARVALID && S_AXI_ARREADY)
                {S_AXI_ARADDR, S_AXI_ARVALID} <= {~a, 1'b0};
            if (S_AXI_RVALID)
            begin
                {d, r} = {S_AXI_RDATA, S_AXI_RRESP};
                S_AXI_RREADY <= 1'b0;
                to = 1'b0;
            end
        end
    endtask
endmodule

`default_nettype wire

/* testbench/pbmd_decoder_bench.sv */
/*
 pbmd_decoder_bench: self-checking bench of the decoder over AXI4-Lite.
 Assumes the host model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module pbmd_decoder_bench;
    logic        I_CLOCK = 1'b0;
    logic        I_RESETN = 1'b0;
    wire  [31:0] S_AXI_WDATA, S_AXI_RDATA;
    wire  [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
    wire  [3:0]  S_AXI_WSTRB;
    wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    wire         S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
    wire         S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    int          fail_count = 0;
    int          compares = 0;
    int          seed = 99;
    int          i, m, q, j, k, n;
    logic [31:0] p, c;
    logic [31:0] all = 32'hFFFF_FFFF;
    logic [7:0]  add_first [5] = '{8'hFF, 8'hFD, 8'h00, 8'hFE, 8'h07};
    logic [7:0]  add_last  [5] = '{8'h04, 8'hFD, 8'hFC, 8'hFE, 8'h0E};

    pbmd_decoder dut_u (.*);
    pbmd_host_model host_u (.*);

    // 200 MHz clock
    always #2.5 I_CLOCK = ~I_CLOCK;

    // expected bit location of density m and adder c
    function automatic logic [31:0] loc(input int m, input logic [7:0] c);
        logic [31:0] v;
        v = (32'h1 << m) + 32'h1 + {{24{c[7]}}, c};
        return (c == 8'h00) ? 32'h0 : {22'h0, v[9:0]};
    endfunction

    // result comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic final_report();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // bus cycles with response checks, and data checks on reads
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        bit         to;
        host_u.wr(a, d, r, to);
        fail_count += int'(to);
        if (to)
            final_report();
        else
            chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e,
                      input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        bit          to;
        host_u.rd(a, d, r, to);
        fail_count += int'(to);
        if (to)
            final_report();
        else
        begin
            chk(d & mk, e);
            chk({30'h0, r}, {30'h0, er});
        end
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge I_CLOCK);
        I_RESETN <= 1'b1;
        @(posedge I_CLOCK);
        rd(8'h00, all, 32'h7, 2'h0);
        rd(8'h04, all, 32'h2, 2'h0);
        rd(8'h08, all, 32'h0, 2'h0);
        rd(8'h0C, all, 32'h0, 2'h0);
        rd(8'h10, all, 32'h0, 2'h0);
        rd(8'h18, all, 32'h7E, 2'h0);
        for (i = 0; i < 5; i++)
            rd(8'h40 + 8'(16 * i), all, (i == 2) ? 32'h4 : 32'(2 + i % 2), 2'h0);
        $display("test reset and kinds done");
        wr(8'h00, 32'h3, 2'h2);
        wr(8'h00, 32'h9, 2'h2);
        rd(8'h00, all, 32'h7, 2'h0);
        wr(8'h3C, 32'h1, 2'h2);
        rd(8'h3C, all, 32'h0, 2'h2);
        $display("test refusals done");
        for (m = 4; m <= 8; m++)
        begin
            wr(8'h00, 32'(m), 2'h0);
            p = 32'h1 << m;
            rd(8'h18, all, p - 32'h2, 2'h0);
            rd(8'h64, all, p - 32'h2, 2'h0);
            for (i = 0; i < 5; i++)
            begin
                rd(8'h48 + 8'(16 * i), all, loc(m, add_first[i]), 2'h0);
                rd(8'h4C + 8'(16 * i), all, loc(m, add_last[i]), 2'h0);
            end
            for (j = 0; j < 2; j++)
                for (q = 0; q < 6; q++)
                begin
                    wr(8'h1C, p + 32'(8 * j + q), 2'h0);
                    c = 32'h8000_0000 | 32'(j << 26) | (q % 2 ? 32'h2_0000 : 32'h1_0000);
                    rd(8'h1C, 32'h3FF, p + 32'(8 * j + q), 2'h0);
                    rd(8'h20, 32'h8703_03FF, c | 32'(q), 2'h0);
                end
        end
        $display("test densities and lock bits done");
        for (k = 0; k < 24; k++)
        begin
            m = 4 + {$random(seed)} % 5;
            c = (k < 3) ? 32'(8'h80 >> (k * 4)) : {$random(seed)} % 256;
            n = (k == 0) ? 31 : {$random(seed)} % 32;
            wr(8'h00, 32'(m), 2'h0);
            wr(8'h0C, c, 2'h0);
            wr(8'h04, 32'(n), 2'h0);
            wr(8'h08, 32'(31 - n), 2'h0);
            rd(8'h14, 32'h3FF, loc(m, c[7:0]), 2'h0);
            rd(8'h44, all, 32'h1 << n, 2'h0);
            rd(8'h84, all, 32'h1 << n, 2'h0);
            rd(8'h54, all, 32'h1 << (31 - n), 2'h0);
            rd(8'h74, all, 32'h1 << (31 - n), 2'h0);
        end
        wr(8'h04, 32'h20, 2'h0);
        wr(8'h08, 32'hFF, 2'h0);
        rd(8'h10, all, 32'h3, 2'h0);
        rd(8'h44, all, 32'h0, 2'h0);
        rd(8'h74, all, 32'h0, 2'h0);
        $display("test random adders and counts done");
        final_report();
    end
endmodule

`default_nettype wire
